// File: core/dso_pkg.sv
package dso_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PV_W   = 16;
  localparam int TRIP_W = 16;
  localparam int CODE_W = 6;
  localparam int NFLAG  = 64;
  localparam int NCOMB  = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PV_UPPER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PV_LOWER = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TRIP     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COMB0    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COMB1    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_COMB2    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TERM_SEL = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h20;

  // field positions
  localparam int CTRL_MODBUS_BIT = 0;
  localparam int COMB_A_LSB      = 0;
  localparam int COMB_B_LSB      = 8;
  localparam int COMB_OP_LSB     = 16;
  localparam int TERM11_LSB      = 0;
  localparam int TERM12_LSB      = 8;
  localparam int RELAY_LSB       = 16;
  localparam int ST_BOOST_BIT    = 0;
  localparam int ST_LINK_BIT     = 1;
  localparam int ST_COMB_LSB     = 2;
  localparam int ST_TERM_LSB     = 5;

  // combiner operators
  localparam logic [1:0] OP_AND = 2'h0;
  localparam logic [1:0] OP_OR  = 2'h1;
  localparam logic [1:0] OP_XOR = 2'h2;

  // output function codes
  localparam logic [CODE_W-1:0] CODE_BOOST = 6'h1F;
  localparam logic [CODE_W-1:0] CODE_LINK  = 6'h20;
  localparam logic [CODE_W-1:0] CODE_LOG1  = 6'h21;
  localparam logic [CODE_W-1:0] CODE_LOG3  = 6'h23;

  // reset values
  localparam logic [PV_W-1:0]   RST_PV_UPPER = 16'h0000;
  localparam logic [PV_W-1:0]   RST_PV_LOWER = 16'h0000;
  localparam logic [TRIP_W-1:0] RST_TRIP     = 16'h0000;
  localparam logic [CODE_W-1:0] RST_TERM     = 6'h00;

  // timing: trip time counts in milliseconds
  localparam int CLK_MHZ      = 250;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
  localparam int TICK_W       = 18;

endpackage : dso_pkg

// File: core/dso_status_out.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module dso_status_out #(
  parameter int TICK_CYCLES = dso_pkg::TICK_CYCLES
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic [dso_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [dso_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [dso_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                        run_mode,
  input  wire logic [dso_pkg::PV_W-1:0]    process_value,
  input  wire logic                        rx_event,
  input  wire logic [dso_pkg::NFLAG-1:0]   other_flags,
  output logic                             pid_boost_request,
  output logic                             link_loss_flag,
  output logic      [dso_pkg::NCOMB-1:0]   combiner_outputs,
  output logic                             term_11_out,
  output logic                             term_12_out,
  output logic                             relay_out
);

  // operand pick: combiner results read as inactive
  function automatic logic operand_pick(
    input logic [dso_pkg::NFLAG-1:0]  flags,
    input logic [dso_pkg::CODE_W-1:0] code
  );
    if (code >= dso_pkg::CODE_LOG1 && code <= dso_pkg::CODE_LOG3) begin
      return 1'b0;
    end
    return flags[code];
  endfunction : operand_pick

  function automatic logic comb_apply(
    input logic [1:0] op,
    input logic       a,
    input logic       b
  );
    logic r;
    r = 1'b0;
    unique case (op)
      dso_pkg::OP_AND: r = a & b;
      dso_pkg::OP_OR:  r = a | b;
      dso_pkg::OP_XOR: r = a ^ b;
      default:         r = 1'b0;
    endcase
    return r;
  endfunction : comb_apply

  // registers
  logic                          modbus_sel_r;
  logic [dso_pkg::PV_W-1:0]      pv_upper_threshold_r;
  logic [dso_pkg::PV_W-1:0]      pv_lower_threshold_r;
  logic [dso_pkg::TRIP_W-1:0]    trip_time_r;
  logic [dso_pkg::CODE_W-1:0]    comb_a_r [dso_pkg::NCOMB];
  logic [dso_pkg::CODE_W-1:0]    comb_b_r [dso_pkg::NCOMB];
  logic [1:0]                    comb_op_r [dso_pkg::NCOMB];
  logic [dso_pkg::CODE_W-1:0]    sel_11_r;
  logic [dso_pkg::CODE_W-1:0]    sel_12_r;
  logic [dso_pkg::CODE_W-1:0]    sel_relay_r;
  logic [dso_pkg::DATA_W-1:0]    rdata_r;
  logic [dso_pkg::TICK_W-1:0]    tick_cnt_r;
  logic [dso_pkg::TRIP_W-1:0]    idle_cnt_r;
  logic                          boost_r;
  logic                          boost_nxt;
  logic                          link_r;
  logic                          link_nxt;
  logic [dso_pkg::NCOMB-1:0]     comb_r;
  logic [dso_pkg::NCOMB-1:0]     comb_nxt;
  logic                          t11_r;
  logic                          t12_r;
  logic                          trelay_r;

  // bus decode
  wire                           wr_ctrl   = reg_wr && reg_addr == dso_pkg::OFS_CTRL;
  wire                           wr_upper  = reg_wr && reg_addr == dso_pkg::OFS_PV_UPPER;
  wire                           wr_lower  = reg_wr && reg_addr == dso_pkg::OFS_PV_LOWER;
  wire                           wr_trip   = reg_wr && reg_addr == dso_pkg::OFS_TRIP;
  wire                           wr_term   = reg_wr && reg_addr == dso_pkg::OFS_TERM_SEL;
  wire                           wr_comb   = reg_wr && (reg_addr == dso_pkg::OFS_COMB0
                                          || reg_addr == dso_pkg::OFS_COMB1
                                          || reg_addr == dso_pkg::OFS_COMB2);
  wire [1:0]                     comb_idx  = reg_addr[3:2];

  // millisecond tick
  wire                           tick      = tick_cnt_r == dso_pkg::TICK_W'(TICK_CYCLES - 1);

  // boost thresholds
  wire                           pv_low    = process_value < pv_lower_threshold_r;
  wire                           pv_high   = process_value > pv_upper_threshold_r;

  // timeout detect
  wire                           timed_out = trip_time_r != '0 && idle_cnt_r >= trip_time_r;
  wire                           idle_full = idle_cnt_r == '1;

  logic [dso_pkg::NFLAG-1:0]     flag_vec;
  logic [dso_pkg::NCOMB-1:0]     opnd_a;
  logic [dso_pkg::NCOMB-1:0]     opnd_b;
  logic [dso_pkg::DATA_W-1:0]    rd_mux;

  // boost request: the thresholds feed nothing else, no alarm path
  always_comb begin
    boost_nxt = boost_r;
    if (!run_mode) begin
      boost_nxt = 1'b0;
    end else if (pv_low) begin
      boost_nxt = 1'b1;
    end else if (pv_high) begin
      boost_nxt = 1'b0;
    end
  end

  // link loss
  always_comb begin
    link_nxt = link_r;
    if (!modbus_sel_r) begin
      link_nxt = 1'b0;
    end else if (rx_event) begin
      link_nxt = 1'b0;
    end else if (timed_out) begin
      link_nxt = 1'b1;
    end
  end

  // flag vector by function code
  always_comb begin
    flag_vec = other_flags;
    flag_vec[dso_pkg::CODE_BOOST] = boost_r;
    flag_vec[dso_pkg::CODE_LINK] = link_r;
    for (int i = 0; i < dso_pkg::NCOMB; i++) begin
      flag_vec[dso_pkg::CODE_LOG1 + i] = comb_r[i];
    end
  end

  // combiners
  always_comb begin
    for (int i = 0; i < dso_pkg::NCOMB; i++) begin
      opnd_a[i] = operand_pick(flag_vec, comb_a_r[i]);
      opnd_b[i] = operand_pick(flag_vec, comb_b_r[i]);
      comb_nxt[i] = comb_apply(comb_op_r[i], opnd_a[i], opnd_b[i]);
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      dso_pkg::OFS_CTRL:     rd_mux[dso_pkg::CTRL_MODBUS_BIT] = modbus_sel_r;
      dso_pkg::OFS_PV_UPPER: rd_mux[dso_pkg::PV_W-1:0] = pv_upper_threshold_r;
      dso_pkg::OFS_PV_LOWER: rd_mux[dso_pkg::PV_W-1:0] = pv_lower_threshold_r;
      dso_pkg::OFS_TRIP:     rd_mux[dso_pkg::TRIP_W-1:0] = trip_time_r;
      dso_pkg::OFS_COMB0, dso_pkg::OFS_COMB1, dso_pkg::OFS_COMB2: begin
        rd_mux[dso_pkg::COMB_A_LSB +: dso_pkg::CODE_W] = comb_a_r[comb_idx];
        rd_mux[dso_pkg::COMB_B_LSB +: dso_pkg::CODE_W] = comb_b_r[comb_idx];
        rd_mux[dso_pkg::COMB_OP_LSB +: 2] = comb_op_r[comb_idx];
      end
      dso_pkg::OFS_TERM_SEL: begin
        rd_mux[dso_pkg::TERM11_LSB +: dso_pkg::CODE_W] = sel_11_r;
        rd_mux[dso_pkg::TERM12_LSB +: dso_pkg::CODE_W] = sel_12_r;
        rd_mux[dso_pkg::RELAY_LSB +: dso_pkg::CODE_W] = sel_relay_r;
      end
      dso_pkg::OFS_STATUS: begin
        rd_mux[dso_pkg::ST_BOOST_BIT] = boost_r;
        rd_mux[dso_pkg::ST_LINK_BIT] = link_r;
        rd_mux[dso_pkg::ST_COMB_LSB +: dso_pkg::NCOMB] = comb_r;
        rd_mux[dso_pkg::ST_TERM_LSB +: 3] = {trelay_r, t12_r, t11_r};
      end
      default: rd_mux = '0;
    endcase
  end

  // register file
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      modbus_sel_r         <= 1'b0;
      pv_upper_threshold_r <= dso_pkg::RST_PV_UPPER;
      pv_lower_threshold_r <= dso_pkg::RST_PV_LOWER;
      trip_time_r          <= dso_pkg::RST_TRIP;
      sel_11_r             <= dso_pkg::RST_TERM;
      sel_12_r             <= dso_pkg::RST_TERM;
      sel_relay_r          <= dso_pkg::RST_TERM;
      rdata_r              <= '0;
      for (int i = 0; i < dso_pkg::NCOMB; i++) begin
        comb_a_r[i]  <= dso_pkg::RST_TERM;
        comb_b_r[i]  <= dso_pkg::RST_TERM;
        comb_op_r[i] <= dso_pkg::OP_AND;
      end
    end else begin
      rdata_r <= reg_rd ? rd_mux : '0;
      if (wr_ctrl) begin
        modbus_sel_r <= reg_wdata[dso_pkg::CTRL_MODBUS_BIT];
      end
      if (wr_upper) begin
        pv_upper_threshold_r <= reg_wdata[dso_pkg::PV_W-1:0];
      end
      if (wr_lower) begin
        pv_lower_threshold_r <= reg_wdata[dso_pkg::PV_W-1:0];
      end
      if (wr_trip) begin
        trip_time_r <= reg_wdata[dso_pkg::TRIP_W-1:0];
      end
      if (wr_term) begin
        sel_11_r    <= reg_wdata[dso_pkg::TERM11_LSB +: dso_pkg::CODE_W];
        sel_12_r    <= reg_wdata[dso_pkg::TERM12_LSB +: dso_pkg::CODE_W];
        sel_relay_r <= reg_wdata[dso_pkg::RELAY_LSB +: dso_pkg::CODE_W];
      end
      if (wr_comb && comb_idx < 2'(dso_pkg::NCOMB)) begin
        comb_a_r[comb_idx]  <= reg_wdata[dso_pkg::COMB_A_LSB +: dso_pkg::CODE_W];
        comb_b_r[comb_idx]  <= reg_wdata[dso_pkg::COMB_B_LSB +: dso_pkg::CODE_W];
        comb_op_r[comb_idx] <= reg_wdata[dso_pkg::COMB_OP_LSB +: 2];
      end
    end
  end

  // tick divider and idle counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tick_cnt_r <= '0;
      idle_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
      if (!modbus_sel_r || rx_event) begin
        idle_cnt_r <= '0;
      end else if (tick && !idle_full) begin
        idle_cnt_r <= idle_cnt_r + 1'b1;
      end
    end
  end

  // status flags and terminals; only three terminals exist
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      boost_r  <= 1'b0;
      link_r   <= 1'b0;
      comb_r   <= '0;
      t11_r    <= 1'b0;
      t12_r    <= 1'b0;
      trelay_r <= 1'b0;
    end else begin
      boost_r  <= boost_nxt;
      link_r   <= link_nxt;
      comb_r   <= comb_nxt;
      t11_r    <= flag_vec[sel_11_r];
      t12_r    <= flag_vec[sel_12_r];
      trelay_r <= flag_vec[sel_relay_r];
    end
  end

  assign reg_rdata         = rdata_r;
  assign pid_boost_request = boost_r;
  assign link_loss_flag    = link_r;
  assign combiner_outputs  = comb_r;
  assign term_11_out       = t11_r;
  assign term_12_out       = t12_r;
  assign relay_out         = trelay_r;

  a_boost_low_set: assert property (@(posedge clk_sys) disable iff (rst)
    run_mode && pv_low |=> pid_boost_request)
    else $error("boost not set below lower threshold");

  a_boost_high_clear: assert property (@(posedge clk_sys) disable iff (rst)
    run_mode && !pv_low && pv_high |=> !pid_boost_request)
    else $error("boost not cleared above upper threshold");

  a_boost_stop_clear: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(run_mode) |=> !pid_boost_request)
    else $error("boost survived leaving run mode");

  a_boost_band_hold: assert property (@(posedge clk_sys) disable iff (rst)
    run_mode && !pv_low && !pv_high |=> pid_boost_request == $past(pid_boost_request))
    else $error("boost changed inside the band");

  a_link_off_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !modbus_sel_r |=> !link_loss_flag)
    else $error("link loss active without protocol select");

  a_link_rx_clear: assert property (@(posedge clk_sys) disable iff (rst)
    link_loss_flag ##0 (modbus_sel_r && !rx_event) [*2] |=> link_loss_flag)
    else $error("link loss dropped without reception");

  a_link_rx_drop: assert property (@(posedge clk_sys) disable iff (rst)
    rx_event |=> !link_loss_flag && idle_cnt_r == '0)
    else $error("reception did not clear link loss");

  a_link_trip_set: assert property (@(posedge clk_sys) disable iff (rst)
    modbus_sel_r && !rx_event && trip_time_r != '0 && idle_cnt_r >= trip_time_r
    |=> link_loss_flag)
    else $error("timeout did not raise link loss");

  a_term_link_route: assert property (@(posedge clk_sys) disable iff (rst)
    sel_12_r == dso_pkg::CODE_LINK |=> term_12_out == $past(link_loss_flag))
    else $error("code 32 did not route link loss");

  a_comb_excl_self: assert property (@(posedge clk_sys) disable iff (rst)
    comb_op_r[1] == dso_pkg::OP_OR && comb_a_r[1] >= dso_pkg::CODE_LOG1
    && comb_a_r[1] <= dso_pkg::CODE_LOG3 && comb_b_r[1] < dso_pkg::CODE_BOOST
    |=> combiner_outputs[1] == $past(other_flags[comb_b_r[1]]))
    else $error("combiner read a combiner result");

  a_comb_xor_apply: assert property (@(posedge clk_sys) disable iff (rst)
    comb_op_r[0] == dso_pkg::OP_XOR && comb_a_r[0] < dso_pkg::CODE_BOOST
    && comb_b_r[0] < dso_pkg::CODE_BOOST
    |=> combiner_outputs[0] == $past(other_flags[comb_a_r[0]] ^ other_flags[comb_b_r[0]]))
    else $error("xor combiner wrong");

  a_relay_comb_route: assert property (@(posedge clk_sys) disable iff (rst)
    sel_relay_r == dso_pkg::CODE_LOG1 |=> relay_out == $past(combiner_outputs[0]))
    else $error("relay did not carry combiner result");

  a_boost_stop_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !run_mode |=> !pid_boost_request)
    else $error("boost active in stop mode");

  a_link_no_early: assert property (@(posedge clk_sys) disable iff (rst)
    modbus_sel_r && !link_loss_flag && (trip_time_r == '0 || idle_cnt_r < trip_time_r)
    |=> !link_loss_flag)
    else $error("link loss raised before the trip time");

  a_idle_clear_off: assert property (@(posedge clk_sys) disable iff (rst)
    !modbus_sel_r |=> idle_cnt_r == '0)
    else $error("idle time counted without protocol select");

  a_idle_count_rise: assert property (@(posedge clk_sys) disable iff (rst)
    modbus_sel_r && !rx_event && tick && !idle_full |=> idle_cnt_r != '0)
    else $error("idle time did not advance on a tick");

  a_term_boost_route: assert property (@(posedge clk_sys) disable iff (rst)
    sel_11_r == dso_pkg::CODE_BOOST |=> term_11_out == $past(pid_boost_request))
    else $error("terminal 11 did not carry boost");

  a_comb_and_apply: assert property (@(posedge clk_sys) disable iff (rst)
    comb_op_r[0] == dso_pkg::OP_AND && comb_a_r[0] < dso_pkg::CODE_BOOST
    && comb_b_r[0] < dso_pkg::CODE_BOOST
    |=> combiner_outputs[0] == $past(other_flags[comb_a_r[0]] & other_flags[comb_b_r[0]]))
    else $error("and combiner wrong");

  a_comb_or_apply: assert property (@(posedge clk_sys) disable iff (rst)
    comb_op_r[0] == dso_pkg::OP_OR && comb_a_r[0] < dso_pkg::CODE_BOOST
    && comb_b_r[0] < dso_pkg::CODE_BOOST
    |=> combiner_outputs[0] == $past(other_flags[comb_a_r[0]] | other_flags[comb_b_r[0]]))
    else $error("or combiner wrong");

  a_comb_bad_op: assert property (@(posedge clk_sys) disable iff (rst)
    comb_op_r[0] != dso_pkg::OP_AND && comb_op_r[0] != dso_pkg::OP_OR
    && comb_op_r[0] != dso_pkg::OP_XOR |=> !combiner_outputs[0])
    else $error("unused operator code gave a result");

  a_comb_excl_last: assert property (@(posedge clk_sys) disable iff (rst)
    comb_op_r[2] == dso_pkg::OP_XOR && comb_b_r[2] >= dso_pkg::CODE_LOG1
    && comb_b_r[2] <= dso_pkg::CODE_LOG3 && comb_a_r[2] < dso_pkg::CODE_BOOST
    |=> combiner_outputs[2] == $past(other_flags[comb_a_r[2]]))
    else $error("last combiner read a combiner result");

endmodule : dso_status_out

// File: verif/drive_status_output_logic_tb.sv
`timescale 1ns/100ps
module drive_status_output_logic_tb;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        run_mode = 1'b0;
  logic [15:0] process_value = 16'h0000;
  logic        rx_event;
  logic        send = 1'b0;
  logic [63:0] other_flags = 64'h0000_0000_0000_0000;
  logic        pid_boost_request;
  logic        link_loss_flag;
  logic [2:0]  combiner_outputs;
  logic        term_11_out;
  logic        term_12_out;
  logic        relay_out;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic [1:0]  op;
  logic        a;
  logic        b;
  logic        e;

  always #2 clk_sys = ~clk_sys;

  dso_status_out #(.TICK_CYCLES(4)) uut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_mode(run_mode),
    .process_value(process_value), .rx_event(rx_event), .other_flags(other_flags),
    .pid_boost_request(pid_boost_request), .link_loss_flag(link_loss_flag),
    .combiner_outputs(combiner_outputs), .term_11_out(term_11_out),
    .term_12_out(term_12_out), .relay_out(relay_out)
  );

  dso_link_src link_src (.clk_sys(clk_sys), .rst(rst), .send(send), .rx_event(rx_event));

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic set_pv(input logic run, input logic [15:0] pv);
    @(posedge clk_sys);
    run_mode      <= run;
    process_value <= pv;
    step(1);
  endtask : set_pv

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i <= 9; i++) begin
      reg_read(8'(4 * i), rd);
      check_word(rd, 32'h0000_0000);
    end
    reg_write(8'h24, 32'hFFFF_FFFF);
    reg_read(8'h24, rd);
    check_word(rd, 32'h0000_0000);
    // boost with hysteresis, terminal 11 set to the boost code
    reg_write(dso_pkg::OFS_PV_UPPER, 32'hFFFF_0800);
    reg_write(dso_pkg::OFS_PV_LOWER, 32'h0000_0400);
    reg_write(dso_pkg::OFS_TERM_SEL, 32'h0021_201F);
    reg_read(dso_pkg::OFS_PV_UPPER, rd);
    check_word(rd, 32'h0000_0800);
    set_pv(1'b0, 16'h0300);
    check_bit(pid_boost_request, 1'b0);
    set_pv(1'b1, 16'h0300);
    check_bit(pid_boost_request, 1'b1);
    step(1);
    check_bit(term_11_out, 1'b1);
    reg_read(dso_pkg::OFS_STATUS, rd);
    check_word(rd, 32'h0000_0021);
    reg_write(dso_pkg::OFS_STATUS, 32'h0000_00FF);
    reg_read(dso_pkg::OFS_STATUS, rd);
    check_word(rd, 32'h0000_0021);
    set_pv(1'b1, 16'h0600);
    check_bit(pid_boost_request, 1'b1);
    set_pv(1'b1, 16'h0900);
    check_bit(pid_boost_request, 1'b0);
    set_pv(1'b1, 16'h0600);
    check_bit(pid_boost_request, 1'b0);
    set_pv(1'b1, 16'h0300);
    set_pv(1'b0, 16'h0300);
    check_bit(pid_boost_request, 1'b0);
    step(1);
    check_bit(term_11_out, 1'b0);
    // link loss: 2-tick trip (a tick is 4 clock cycles here), protocol still off
    reg_write(dso_pkg::OFS_TRIP, 32'h0000_0002);
    step(20);
    check_bit(link_loss_flag, 1'b0);
    reg_write(dso_pkg::OFS_CTRL, 32'h0000_0001);
    step(3);
    check_bit(link_loss_flag, 1'b0);
    step(10);
    check_bit(link_loss_flag, 1'b1);
    step(20);
    check_bit(link_loss_flag, 1'b1);
    check_bit(term_12_out, 1'b1);
    @(posedge clk_sys);
    send <= 1'b1;
    @(posedge clk_sys);
    send <= 1'b0;
    step(1);
    check_bit(link_loss_flag, 1'b0);
    step(13);
    check_bit(link_loss_flag, 1'b1);
    reg_write(dso_pkg::OFS_CTRL, 32'h0000_0000);
    step(1);
    check_bit(link_loss_flag, 1'b0);
    step(1);
    check_bit(term_12_out, 1'b0);
    // combiner: a combiner result as operand reads as zero
    reg_write(dso_pkg::OFS_COMB1, 32'h0001_0521);
    reg_write(dso_pkg::OFS_COMB2, 32'h0002_2206);
    for (int o = 0; o < 4; o++) begin
      op = 2'(o);
      reg_write(dso_pkg::OFS_COMB0, {14'h0000, op, 16'h0605});
      for (int k = 0; k < 4; k++) begin
        a = k[0];
        b = k[1];
        e = (op == 2'h0) ? (a & b) : (op == 2'h1) ? (a | b) : (op == 2'h2) ? (a ^ b) : 1'b0;
        @(posedge clk_sys);
        other_flags[5] <= a;
        other_flags[6] <= b;
        step(1);
        check_bit(combiner_outputs[0], e);
        check_bit(combiner_outputs[1], a);
        check_bit(combiner_outputs[2], b);
        step(1);
        check_bit(relay_out, e);
      end
    end
    complete_run();
  end
endmodule : drive_status_output_logic_tb

// File: verif/dso_link_src.sv
`timescale 1ns/100ps
// serial link partner: one reception pulse per send request
module dso_link_src (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic send,
  output logic      rx_event
);
  logic send_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      send_r <= 1'b0;
    end else begin
      send_r <= send;
    end
  end
  // one-cycle pulse on the rising edge of a request
  assign rx_event = send & ~send_r;
endmodule : dso_link_src
